// >>> src/svr_params.svh
// svr_params.svh: timing constants and reset values for the supervisor block
// assumes a 50 MHz reference clock; counts derive from times in their own units
`ifndef SVR_PARAMS_SVH
`define SVR_PARAMS_SVH

`define SVR_CLK_HZ 50000000
// nominal reset pulse, in ms
`define SVR_RST_PULSE_MS 200
// least pulse left after a brownout inside a pulse, in ms
`define SVR_RST_MIN_MS 140
// watchdog timeout, in ms
`define SVR_WDT_TIMEOUT_MS 1600
// manual reset debounce time, in us
`define SVR_DEBOUNCE_US 20
`define SVR_RST_PULSE_CYC ((`SVR_CLK_HZ / 1000) * `SVR_RST_PULSE_MS)
`define SVR_RST_MIN_CYC ((`SVR_CLK_HZ / 1000) * `SVR_RST_MIN_MS)
`define SVR_WDT_TIMEOUT_CYC ((`SVR_CLK_HZ / 1000) * `SVR_WDT_TIMEOUT_MS)
`define SVR_DEBOUNCE_CYC ((`SVR_CLK_HZ / 1000000) * `SVR_DEBOUNCE_US)
// synchroniser reset value: idle levels (inputs released, supply good)
// order: manual_reset_n, watchdog_kick, kick_undriven, supply_low, power_fail_sense
`define SVR_SYNC_RST 5'h10

`endif

// >>> src/svr_pkg.sv
// svr_pkg.sv: types shared by the supervisor block
// assumes the including design reads svr_params.svh for numbers
package svr_pkg;
    // raw indications as they arrive from the analog front end
    typedef struct packed {
        logic manual_reset_n;   // pushbutton or logic, active low
        logic watchdog_kick;    // toggled by host
        logic kick_undriven;    // front end reports floating kick
        logic supply_low;       // supply below reset threshold
        logic power_fail_sense; // monitored voltage below reference
    } svr_ind_s;

    // reset pulse sequencer states
    typedef enum logic [1:0] {
        SVR_HOLD,   // held by level trigger
        SVR_PULSE,  // stretching the pulse
        SVR_IDLE    // reset released
    } svr_rst_e;
endpackage

// >>> src/svr_sync.sv
// svr_sync.sv: two-flop synchroniser for a bundle of asynchronous levels
// assumes inputs come from pins outside the clock domain
`timescale 1ns/1ps
`include "svr_params.svh"
module svr_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // next values: plain shift
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // registers, reset to idle levels
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            o_sync <= sync_d;
        end
    end
endmodule // svr_sync

// >>> src/svr_supervisor.sv
// svr_supervisor.sv: reset stretcher, watchdog and power-fail warning
// assumes digital indications from an analog front end, and one 50 MHz clock
// Overview of operation
// R1 - manual reset low starts reset pulse
// R2 - warning output low while sense reports low
// R3 - kick steady for timeout expires watchdog
// R4 - undriven kick disables watchdog entirely
// R5 - timer clears on reset, undriven, kick edges
// R6 - triggered reset held low nominal pulse
// R7 - reset held low while supply low
// R8 - full pulse after supply or button release
// R9 - expiry never asserts reset directly
// R10 - expiry output low until timer cleared
// R11 - expiry output low while supply low
// R12 - expiry output has no stretching delay
// R13 - active-high reset is exact inverse
// R14 - build options drop low reset, watchdog
// R15 - brownout inside pulse leaves least time
// R16 - synchronise inputs, debounce manual reset
// R17 - terminal counts set by parameters
`timescale 1ns/1ps
`include "svr_params.svh"
module svr_supervisor
    import svr_pkg::*;
#(
    parameter int RST_PULSE_CYC = `SVR_RST_PULSE_CYC,   // shorten in simulation
    parameter int RST_MIN_CYC = `SVR_RST_MIN_CYC,
    parameter int WDT_TIMEOUT_CYC = `SVR_WDT_TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = `SVR_DEBOUNCE_CYC,
    parameter bit HAS_RESET_N = 1'b1,    // active-low reset output present
    parameter bit HAS_WATCHDOG = 1'b1    // kick input and expiry output present
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire svr_pkg::svr_ind_s i_ind,
    output logic o_reset_n,
    output logic o_reset,
    output logic o_power_fail_warn_n,
    output logic o_watchdog_expired_n
);
    import svr_pkg::*;

    localparam int CW = 32;

    svr_ind_s sync_ind;                 // synchronised indications
    logic [4:0] sync_bits;
    logic mr_db_q, mr_db_d;             // debounced manual reset level
    logic [CW-1:0] db_cnt_q, db_cnt_d;
    svr_rst_e st_q, st_d;
    logic [CW-1:0] rst_cnt_q, rst_cnt_d;  // remaining pulse cycles
    logic [CW-1:0] wdt_cnt_q, wdt_cnt_d;
    logic kick_prev_q, kick_prev_d;
    logic expired_q, expired_d;         // sticky timer completion
    logic rst_n_q, rst_n_d;
    logic rst_q, rst_d;
    logic pfw_n_q, pfw_n_d;
    logic wdo_n_q, wdo_n_d;
    logic level_trig;
    logic wdt_clear;

    // inputs from pins cross two flops before any use
    // idle reset levels: no false kick edge and no warning glitch after reset
    svr_sync #(.WIDTH(5), .RST_VAL(`SVR_SYNC_RST)) u_sync ( // R16
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_ind),
        .o_sync(sync_bits)
    );
    assign sync_ind = sync_bits;

    // debounce: new level accepted only after it holds steady
    always_comb begin
        db_cnt_d = '0;
        mr_db_d = mr_db_q;
        if (sync_ind.manual_reset_n != mr_db_q) begin
            if (db_cnt_q >= CW'(DEBOUNCE_CYC - 1)) begin
                mr_db_d = sync_ind.manual_reset_n; // R16
            end else begin
                db_cnt_d = db_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mr_db_q <= 1'b1;
            db_cnt_q <= '0;
        end else begin
            mr_db_q <= mr_db_d;
            db_cnt_q <= db_cnt_d;
        end
    end

    // level triggers hold reset; watchdog expiry is not among them
    assign level_trig = sync_ind.supply_low || !mr_db_q; // R1 R7 R9

    // reset sequencer: hold while triggered, then stretch
    always_comb begin
        st_d = st_q;
        rst_cnt_d = rst_cnt_q;
        case (st_q)
            SVR_HOLD: begin
                // release of the trigger starts the full pulse
                if (!level_trig) begin
                    st_d = SVR_PULSE;
                    rst_cnt_d = CW'(RST_PULSE_CYC - 1); // R8 R17
                end
            end
            SVR_PULSE: begin
                if (sync_ind.supply_low) begin
                    // brownout mid-pulse: keep at least the least time after
                    st_d = SVR_PULSE;
                    if (rst_cnt_q < CW'(RST_MIN_CYC - 1)) begin
                        rst_cnt_d = CW'(RST_MIN_CYC - 1); // R15
                    end
                end else if (!mr_db_q) begin
                    st_d = SVR_HOLD; // R1
                end else if (rst_cnt_q == '0) begin
                    st_d = SVR_IDLE; // R6
                end else begin
                    rst_cnt_d = rst_cnt_q - 1'b1; // R6
                end
            end
            SVR_IDLE: begin
                if (level_trig) begin
                    st_d = SVR_HOLD; // R1 R7
                end
            end
            default: st_d = SVR_HOLD;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= SVR_HOLD;
            rst_cnt_q <= '0;
        end else begin
            st_q <= st_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // watchdog: timer clears on reset, undriven kick, or any kick edge
    assign wdt_clear = (st_q != SVR_IDLE) || sync_ind.kick_undriven
        || (sync_ind.watchdog_kick != kick_prev_q); // R5

    always_comb begin
        kick_prev_d = sync_ind.watchdog_kick;
        wdt_cnt_d = wdt_cnt_q;
        expired_d = expired_q;
        if (!HAS_WATCHDOG || wdt_clear) begin
            wdt_cnt_d = '0; // R4 R5
            expired_d = 1'b0; // R10
        end else if (wdt_cnt_q >= CW'(WDT_TIMEOUT_CYC - 1)) begin
            expired_d = 1'b1; // R3 R17
        end else begin
            wdt_cnt_d = wdt_cnt_q + 1'b1; // R3
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wdt_cnt_q <= '0;
            kick_prev_q <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            wdt_cnt_q <= wdt_cnt_d;
            kick_prev_q <= kick_prev_d;
            expired_q <= expired_d;
        end
    end

    // outputs, each from a flop; both reset polarities from one decision
    always_comb begin
        rst_n_d = HAS_RESET_N ? !(st_d != SVR_IDLE) : 1'b1; // R14
        rst_d = (st_d != SVR_IDLE); // R13
        pfw_n_d = !sync_ind.power_fail_sense; // R2
        // no stretching: follows supply directly, plus sticky expiry
        wdo_n_d = HAS_WATCHDOG ? !(expired_d || sync_ind.supply_low) : 1'b1; // R10 R11 R12 R14
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_n_q <= ~HAS_RESET_N; // R14 absent output stays high
            rst_q <= 1'b1;
            pfw_n_q <= 1'b1;
            wdo_n_q <= 1'b1;
        end else begin
            rst_n_q <= rst_n_d;
            rst_q <= rst_d;
            pfw_n_q <= pfw_n_d;
            wdo_n_q <= wdo_n_d;
        end
    end

    assign o_reset_n = rst_n_q;
    assign o_reset = rst_q;
    assign o_power_fail_warn_n = pfw_n_q;
    assign o_watchdog_expired_n = wdo_n_q;

    // checks
    sequence s_supply_low;
        sync_ind.supply_low;
    endsequence

    chk_supply_holds_reset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
        s_supply_low |=> o_reset) else $error("reset not held during low supply");
    chk_reset_inverse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R13
        o_reset == !o_reset_n || !HAS_RESET_N) else $error("reset outputs not inverse");
    chk_pf_follows: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R2
        1'b1 |=> o_power_fail_warn_n == !$past(sync_ind.power_fail_sense))
        else $error("power fail warning wrong");
    chk_wdo_low_supply: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R11
        s_supply_low |=> !o_watchdog_expired_n || !HAS_WATCHDOG)
        else $error("expiry output high at low supply");
    chk_undriven_noexp: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R4
        sync_ind.kick_undriven |=> !expired_q) else $error("expiry while kick undriven");
    // the edge is seen and cleared at one edge, so the count is zero at the next
    chk_kick_clears: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R5
        $changed(sync_ind.watchdog_kick) |=> wdt_cnt_q == '0)
        else $error("kick edge did not clear timer");
    chk_expiry_noreset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R9
        (st_q == SVR_IDLE && !level_trig && expired_q) |=> st_q == SVR_IDLE)
        else $error("expiry caused reset");
    chk_release_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
        (st_q == SVR_HOLD && !level_trig)
        |=> st_q == SVR_PULSE && rst_cnt_q == CW'(RST_PULSE_CYC - 1))
        else $error("pulse not loaded at release");
    chk_brownout_min: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R15
        (st_q == SVR_PULSE && sync_ind.supply_low) |=> rst_cnt_q >= CW'(RST_MIN_CYC - 1))
        else $error("brownout pulse too short");
    chk_wdo_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R10
        (expired_q && !wdt_clear) |=> expired_q) else $error("expiry dropped early");
endmodule // svr_supervisor

// >>> tb/svr_host_model.sv
// svr_host_model.sv: host processor side, toggles the watchdog kick line
// assumes the bench raises i_run while host software is alive
`timescale 1ns/1ps
module svr_host_model (
    input wire logic i_ref_clk,
    input wire logic i_run,
    input wire logic [7:0] i_half,
    output logic o_kick
);
    int cnt; // cycles since last kick edge
    initial begin
        o_kick = 1'b0;
        cnt = 0;
    end
    // a stalled host simply holds its last level, as real firmware would
    always @(negedge i_ref_clk) begin
        if (i_run) begin
            // >= so that a shortened spacing takes effect at once
            if (cnt >= int'(i_half) - 1) begin
                cnt <= 0;
                o_kick <= ~o_kick;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // svr_host_model

// >>> tb/test_supervisor_reset_watchdog.sv
// test_supervisor_reset_watchdog.sv: self-checking bench for the supervisor
// assumes shortened counts; inputs change on the falling edge only
`timescale 1ns/1ps
module test_supervisor_reset_watchdog;
    import svr_pkg::*;
    localparam int PULSE = 20; // shortened reset pulse
    localparam int MINP = 14; // least pulse after a brownout
    localparam int WDT = 50; // shortened watchdog timeout
    localparam int DEB = 3; // manual reset debounce
    logic i_ref_clk;
    logic i_reset_n;
    svr_ind_s ind; // indications from the bench
    svr_ind_s dut_ind; // same, with the host's kick merged in
    logic run; // host alive
    logic [7:0] half; // host kick spacing
    logic kick;
    logic o_reset_n;
    logic o_reset;
    logic o_power_fail_warn_n;
    logic o_watchdog_expired_n;
    logic opt_reset_n; // build without low reset and watchdog
    logic opt_reset;
    logic opt_expired_n;
    int errors;
    int tests_run;
    int n;

    // kick comes from the host model, the rest from the bench
    always_comb begin
        dut_ind = ind;
        dut_ind.watchdog_kick = kick;
    end

    svr_supervisor #(.RST_PULSE_CYC(PULSE), .RST_MIN_CYC(MINP), .WDT_TIMEOUT_CYC(WDT),
        .DEBOUNCE_CYC(DEB)) dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_ind(dut_ind), .o_reset_n(o_reset_n), .o_reset(o_reset),
        .o_power_fail_warn_n(o_power_fail_warn_n),
        .o_watchdog_expired_n(o_watchdog_expired_n));

    // reduced build: active-high reset alone, no watchdog
    svr_supervisor #(.RST_PULSE_CYC(PULSE), .RST_MIN_CYC(MINP), .WDT_TIMEOUT_CYC(WDT),
        .DEBOUNCE_CYC(DEB), .HAS_RESET_N(1'b0), .HAS_WATCHDOG(1'b0)) dut_opt (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ind(dut_ind),
        .o_reset_n(opt_reset_n), .o_reset(opt_reset), .o_power_fail_warn_n(),
        .o_watchdog_expired_n(opt_expired_n));

    svr_host_model host (.i_ref_clk(i_ref_clk), .i_run(run), .i_half(half), .o_kick(kick));

    // 50 MHz reference
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    task automatic close_out();
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_n(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge i_ref_clk);
    endtask

    // count cycles until reset (wd=0) or expiry (wd=1) output reaches lvl
    task automatic wait_lvl(input bit wd, input logic lvl, output int c);
        c = 0;
        while ((wd ? o_watchdog_expired_n : o_reset_n) !== lvl) begin
            cyc(1);
            c++;
            if (c > 400) begin
                errors++;
                close_out();
            end
        end
    endtask

    task automatic t_power_up();
        chk("reset_n", 1'b0, o_reset_n);
        chk("reset", 1'b1, o_reset);
        wait_lvl(0, 1'b1, n);
        chk_n("pulse", PULSE, PULSE + 8, n);
        chk("reset", 1'b0, o_reset);
    endtask

    task automatic t_supply();
        ind.supply_low = 1'b1;
        cyc(4);
        chk("reset_n", 1'b0, o_reset_n);
        chk("expired_n", 1'b0, o_watchdog_expired_n);
        chk("opt reset_n", 1'b1, opt_reset_n);
        chk("opt reset", 1'b1, opt_reset);
        chk("opt expired_n", 1'b1, opt_expired_n);
        cyc(40);
        chk("reset_n", 1'b0, o_reset_n);
        ind.supply_low = 1'b0;
        cyc(4);
        chk("expired_n", 1'b1, o_watchdog_expired_n);
        wait_lvl(0, 1'b1, n);
        chk_n("pulse", PULSE - 4, PULSE + 4, n);
    endtask

    task automatic t_manual();
        ind.manual_reset_n = 1'b0;
        cyc(DEB + 5);
        chk("reset_n", 1'b0, o_reset_n);
        cyc(30);
        ind.manual_reset_n = 1'b1;
        wait_lvl(0, 1'b1, n);
        chk_n("pulse", PULSE, PULSE + DEB + 8, n);
    endtask

    // brownout blip while the pulse is already counting down
    task automatic t_brownout();
        ind.supply_low = 1'b1;
        cyc(6);
        ind.supply_low = 1'b0;
        cyc(12);
        ind.supply_low = 1'b1;
        cyc(2);
        ind.supply_low = 1'b0;
        wait_lvl(0, 1'b1, n);
        chk_n("pulse", MINP, PULSE + 6, n);
    endtask

    task automatic t_pfail();
        ind.power_fail_sense = 1'b1;
        cyc(4);
        chk("warn_n", 1'b0, o_power_fail_warn_n);
        ind.power_fail_sense = 1'b0;
        cyc(4);
        chk("warn_n", 1'b1, o_power_fail_warn_n);
    endtask

    task automatic t_watchdog();
        // non-blocking: the host model samples these on the same falling edge
        half <= 8'h14;
        cyc(200);
        chk("expired_n", 1'b1, o_watchdog_expired_n);
        half <= 8'h04;
        cyc(10);
        run <= 1'b0;
        wait_lvl(1, 1'b0, n);
        chk_n("timeout", WDT - 8, WDT + 6, n);
        cyc(30);
        chk("expired_n", 1'b0, o_watchdog_expired_n);
        chk("reset_n", 1'b1, o_reset_n);
        chk("opt expired_n", 1'b1, opt_expired_n);
        run <= 1'b1;
        cyc(10);
        chk("expired_n", 1'b1, o_watchdog_expired_n);
    endtask

    task automatic t_undriven();
        run <= 1'b0;
        ind.kick_undriven = 1'b1;
        cyc(WDT * 3);
        chk("expired_n", 1'b1, o_watchdog_expired_n);
        ind.kick_undriven = 1'b0;
        wait_lvl(1, 1'b0, n);
        chk_n("timeout", WDT, WDT + 8, n);
        run <= 1'b1;
        cyc(10);
    endtask

    initial begin
        ind = '{manual_reset_n: 1'b1, watchdog_kick: 1'b0, kick_undriven: 1'b0,
            supply_low: 1'b0, power_fail_sense: 1'b0};
        run = 1'b1;
        half = 8'h04;
        i_reset_n = 1'b0;
        errors = 0;
        tests_run = 0;
        cyc(20);
        i_reset_n = 1'b1;
        t_power_up();
        t_supply();
        t_manual();
        t_brownout();
        t_pfail();
        t_watchdog();
        t_undriven();
        close_out();
    end
endmodule // test_supervisor_reset_watchdog
